// >>> src/roa_adjust.sv
/*
  Oscillation adjustment: divides the oscillator into seconds, once per
  20 or 60 seconds stretches or shortens one second, and drives the
  oscillator clock and a one hertz pulse out.
  Assumes OSC_TICK is a one-cycle pulse per oscillator period, sync to
  CLK_SYS, and ADJ_BYTE is held stable by the serial register file.
*/
`timescale 1ns/1ns
`include "roa_consts.svh"
module roa_adjust #(
  // Last divider index of a nominal second, and pulse-high span
  parameter logic [14:0] LAST_TICK  = `ROA_OSC_PER_SEC,
  parameter logic [14:0] PULSE_HIGH = `ROA_PULSE_HIGH
) (
  // Clock and reset
  input  wire logic           CLK_SYS,
  input  wire logic           NRST,
  // Oscillator
  input  wire logic           OSC_TICK,
  input  wire logic           OSC_LEVEL,
  // Adjustment byte
  input  wire roa_pkg::roa_adj_t ADJ_BYTE,
  // Outputs
  output logic                CRYSTAL_CLOCK_OUTPUT_PIN,
  output logic                INTERRUPT_OUTPUT_PIN,
  output logic                SECOND_TICK
);
  import roa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // One bit above the nominal count so fast seconds cannot wrap
  logic [15:0] div_ff;
  logic [5:0]  sec_ff;
  logic [6:0]  steps_ff;
  roa_dir_t    dir_ff;
  logic        clk_ff;
  logic        pulse_ff;
  logic        tick_ff;
  logic        correction_value_field_nz;
  logic        correction_period_select;
  logic [6:0]  correction_value_field;
  logic [6:0]  mag;
  roa_dir_t    dir;
  logic [5:0]  period;
  logic        sec_end;
  logic [15:0] limit;

  // Byte layout
  assign correction_period_select = ADJ_BYTE[`ROA_SEL_BIT];
  assign correction_value_field =
    ADJ_BYTE[`ROA_VAL_MSB:`ROA_VAL_LSB];

  // Decode value field into direction and step count
  function automatic roa_dir_t dec_dir(input logic [6:0] v);
    if (v == 7'h00 || v == 7'h01 || v == 7'h40 || v == 7'h41) begin
      dec_dir = ROA_NONE;
    end else if (v[6]) begin
      dec_dir = ROA_SLOW;
    end else begin
      dec_dir = ROA_FAST;
    end
  endfunction

  // Fast codes are a distance from 01h, slow ones from 80h
  function automatic logic [6:0] dec_mag(input logic [6:0] v);
    if (v[6]) begin
      dec_mag = 7'(8'h80 - {1'b0, v});
    end else begin
      dec_mag = 7'(v - 7'h01);
    end
  endfunction

  assign dir    = dec_dir(correction_value_field);
  assign mag    = dec_mag(correction_value_field);
  assign correction_value_field_nz = (dir != ROA_NONE);
  assign period = correction_period_select ? `ROA_PERIOD_LONG
                                           : `ROA_PERIOD_SHORT;

  // Last divider index of this second; slow removes, fast adds
  always_comb begin
    unique case (dir_ff)
      ROA_SLOW: limit = 16'({1'b0, LAST_TICK} - {9'h000, steps_ff});
      ROA_FAST: limit = 16'({1'b0, LAST_TICK} + {9'h000, steps_ff});
      ROA_NONE: limit = {1'b0, LAST_TICK};
      default:  limit = {1'b0, LAST_TICK};
    endcase
  end
  assign sec_end = OSC_TICK && (div_ff >= limit);

  ////////////////////////////////////////////////////////////////////////
  // Sub-second divider; cleared to zero at the end of every second
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      div_ff <= 16'h0000;
    end else if (sec_end) begin
      div_ff <= 16'h0000;
    end else if (OSC_TICK) begin
      div_ff <= 16'(div_ff + 16'h0001);
    end
  end

  // Second counter within interval; correction armed on its last second
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sec_ff   <= 6'h00;
      dir_ff   <= ROA_NONE;
      steps_ff <= 7'h00;
    end else if (sec_end) begin
      if (sec_ff >= 6'(period - 6'd2)) begin
        sec_ff   <= (sec_ff >= 6'(period - 6'd1)) ? 6'h00
                                                  : 6'(sec_ff + 6'd1);
        dir_ff   <= (sec_ff == 6'(period - 6'd2)) ? dir : ROA_NONE;
        steps_ff <= correction_value_field_nz ? mag : 7'h00;
      end else begin
        sec_ff   <= 6'(sec_ff + 6'd1);
        dir_ff   <= ROA_NONE;
        steps_ff <= 7'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock out and one hertz pulse; registered for clean pins
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      clk_ff <= 1'b0;
    end else begin
      clk_ff <= OSC_LEVEL;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pulse_ff <= 1'b0;
      tick_ff  <= 1'b0;
    end else begin
      pulse_ff <= (div_ff < {1'b0, PULSE_HIGH});
      tick_ff  <= sec_end;
    end
  end

  assign CRYSTAL_CLOCK_OUTPUT_PIN = clk_ff;
  assign INTERRUPT_OUTPUT_PIN     = pulse_ff;
  assign SECOND_TICK              = tick_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pins: skip the first edge after reset, the register was held low
  a_clk_follows: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    $past(NRST) |-> CRYSTAL_CLOCK_OUTPUT_PIN == $past(OSC_LEVEL))
    else $error("clock output does not follow oscillator");

  a_pulse_reg: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    $past(NRST) |->
    INTERRUPT_OUTPUT_PIN == $past(div_ff < {1'b0, PULSE_HIGH}))
    else $error("pulse output wrong");

  // Decoding of the adjustment byte
  a_no_corr_zero: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    sec_end && ADJ_BYTE[6:0] == 7'h00 |=>
    dir_ff == ROA_NONE && steps_ff == 7'h00)
    else $error("correction active with zero value");

  a_null_codes: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    (correction_value_field == 7'h41 || correction_value_field == 7'h01 ||
     correction_value_field == 7'h40) |-> dir == ROA_NONE)
    else $error("null code decoded as correction");

  a_slow_code: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    correction_value_field == 7'h46 |-> dir == ROA_SLOW && mag == 7'd58)
    else $error("slow code decode wrong");

  a_fast_code: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    correction_value_field == 7'h09 |-> dir == ROA_FAST && mag == 7'd8)
    else $error("fast code decode wrong");

  // Interval bookkeeping
  a_sel_period: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    period == (ADJ_BYTE[7] ? 6'd60 : 6'd20))
    else $error("interval length wrong");

  a_sec_bound: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    sec_ff < 6'd60)
    else $error("second counter out of range");

  // Only the armed second is altered, and by the decoded amount
  a_plain_second: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    (sec_end && sec_ff != 6'(period - 6'd2)) |=> dir_ff == ROA_NONE)
    else $error("uncorrected second altered");

  a_corr_armed: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    sec_end && sec_ff == 6'(period - 6'd2) && correction_value_field_nz
    |=> dir_ff == $past(dir) && steps_ff == $past(mag))
    else $error("correction not armed as decoded");

  a_div_stops: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    sec_end |-> div_ff == limit)
    else $error("second overran its length");

  a_div_window: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    div_ff <= 16'({1'b0, LAST_TICK} + 16'd63))
    else $error("divider beyond longest second");

  a_tick_after: assert property (@(posedge CLK_SYS)
    disable iff (!NRST)
    sec_end |=> SECOND_TICK)
    else $error("second tick missing");

  c_fast: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    sec_end && dir_ff == ROA_FAST);

  c_slow: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    sec_end && dir_ff == ROA_SLOW);

  c_wrap: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    sec_end && sec_ff == 6'd59);

  c_neutral: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    sec_end && sec_ff == 6'd18 && dir == ROA_NONE);

  c_long_fast: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    sec_end && dir_ff == ROA_FAST && correction_period_select);
endmodule

// >>> shared/roa_consts.svh
/*
  Constants of the oscillation adjustment block: field layout of the
  adjustment byte, correction intervals and oscillator divider figures.
  Assumes inclusion through the package or a design file by bare name.
*/
`ifndef ROA_CONSTS_SVH
`define ROA_CONSTS_SVH

`define ROA_SEL_BIT      7
`define ROA_VAL_MSB      6
`define ROA_VAL_LSB      0
`define ROA_ADJ_RESET    8'h00
`define ROA_PERIOD_SHORT 6'd20
`define ROA_PERIOD_LONG  6'd60
`define ROA_OSC_PER_SEC  15'd32767
`define ROA_PULSE_HIGH   15'd16384

`endif

// >>> shared/roa_pkg.sv
/*
  Types of the oscillation adjustment block.
  Assumes roa_consts.svh is on the include path.
*/
package roa_pkg;
  typedef logic [7:0] roa_adj_t;
  typedef enum logic [1:0] {
    ROA_NONE  = 2'b00,
    ROA_SLOW  = 2'b01,
    ROA_FAST  = 2'b10
  } roa_dir_t;
endpackage

// >>> verif/roa_adjust_tb.sv
/*
  Bench of the oscillation adjustment block: second lengths, pin outputs.
  Assumes roa_pkg and roa_consts.svh compiled first; one tick per cycle.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t: got %0d want %0d", $time, a, b); end end
module roa_adjust_tb;
  import roa_pkg::*;
  int              errors = 0;
  int              checks = 0;
  logic            clk_sys = 1'b0;
  logic            nrst = 1'b0;
  logic            osc_tick = 1'b1;
  logic            osc_level = 1'b0;
  roa_adj_t        adj_byte = 8'h00;
  logic            crystal;
  logic            interrupt_output_pin;
  logic            tick;
  // Shortened seconds keep the run small; correction sizes unchanged
  localparam int   SEC_LEN = 256;
  localparam int   HI_LEN  = 128;

  always #4 clk_sys = ~clk_sys;
  // Level toggles freely so a stuck clock output shows at once
  always @(posedge clk_sys) osc_level <= ~osc_level;

  roa_adjust #(
    .LAST_TICK  (15'd255),
    .PULSE_HIGH (15'd128)
  ) dut (
    .CLK_SYS                  (clk_sys),
    .NRST                     (nrst),
    .OSC_TICK                 (osc_tick),
    .OSC_LEVEL                (osc_level),
    .ADJ_BYTE                 (adj_byte),
    .CRYSTAL_CLOCK_OUTPUT_PIN (crystal),
    .INTERRUPT_OUTPUT_PIN     (interrupt_output_pin),
    .SECOND_TICK              (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Cycles from one second tick to the next, and pulse-high cycles
  task automatic sec(output int len, output int hi);
    len = 0;
    hi = 0;
    do begin
      @(negedge clk_sys);
      len++;
      hi += int'(interrupt_output_pin === 1'b1);
    end while (tick !== 1'b1);
  endtask

  // Second index per-1 of each interval carries the correction d
  task automatic run(input roa_adj_t adj, input int per, input int d);
    int len;
    int hi;
    @(posedge clk_sys);
    adj_byte <= adj;
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    sec(len, hi);
    for (int k = 1; k <= per; k++) begin
      sec(len, hi);
      `CHK(len, (k == per - 1) ? SEC_LEN + d : SEC_LEN)
      `CHK(hi, HI_LEN)
    end
  endtask

  task automatic pins();
    logic prev;
    @(negedge clk_sys);
    prev = osc_level;
    repeat (64) begin
      @(negedge clk_sys);
      `CHK(crystal, prev)
      prev = osc_level;
    end
  endtask

  task automatic fast_short();
    run(8'h09, 20, 8);
  endtask

  task automatic slow_short();
    run(8'h46, 20, -58);
  endtask

  task automatic fast_long();
    run(8'h99, 60, 24);
  endtask

  // Zero field and the other neutral codes leave every second nominal
  task automatic neutral();
    roa_adj_t codes[4] = '{8'h00, 8'h01, 8'h40, 8'h41};
    foreach (codes[i]) run(codes[i], 20, 0);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // About 190 short seconds of 256 cycles each, with margin
  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    pins();
    fast_short();
    slow_short();
    fast_long();
    neutral();
    stop_test();
  end
endmodule
